// file: rtl/ssir_core.sv
// Status word, interrupt output, result buffering and conversion sequencing.
// Assumes the two-wire link clock drives link_scl_i and that the pad logic
// resolves the open-drain wires from the output enables.
`include "ssir_regs.svh"

// Notes on behaviour
// - An event raises the interrupt only when its mask bit is set.
// - The interrupt pin works only while the disable bit is zero.
// - Any set status bit freezes the status word until status or upper read.
// - The releasing read also returns the interrupt pin high.
// - Sleep, reset, shutdown and software reset clear a pending interrupt.
// - Reading status clears error bits, fault channel and the interrupt.
// - Disable bit one holds the pin high; a pending interrupt stays set.
// - Scan mode converts selected channels in turn, each replacing its result.
// - Results go to an internal buffer; upper read makes them visible.
// - Last channel of the group done with ready enable pulls interrupt low.
// - Sleep or shutdown clears all upper and lower result data.
// - Status holds one unread flag per channel, tracking result reads.
// - Upper read loads the lower word and clears that unread flag.
// - Lower read alone keeps returning the word of the last upper read.
// - After power-up the block sleeps until the host clears sleep.
// - Conversion lasts reference count times 16 reference periods.
// - Fault report mask resets with every interrupt source disabled.
// - Scan enable one scans several channels instead of a single one.
// - Scan group zero converts channels 0 and 1.
// - Channel field zero picks channel 0 for single conversion.
// - Sleep field zero starts conversions; one keeps the block asleep.
// - Clock select zero uses the internal clock, one the external input.
module ssir_core
  import ssir_pkg::*;
(
  // Clock and reset.
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  // Two-wire register link.
  input  wire logic                 link_scl_i,
  input  wire logic                 sda_i,
  output logic                      link_scl_oe_o,
  output logic                      sda_oe_o,
  // Sensor and control pins.
  input  wire logic                 ext_clk_i,
  input  wire logic [`SSIR_NCH-1:0] sens_i,
  input  wire logic                 shutdown_in_i,
  // Outputs.
  output logic                      irq_out_n_o,
  output ssir_anl_t                 anl_cfg_o
);

  localparam logic [`SSIR_RES_W-1:0] RES_MAX = '1;

  function automatic logic [19:0] x16(input logic [15:0] v);
    x16 = {v, 4'h0};
  endfunction

  function automatic ssir_st_t st_rst();
    ssir_st_t s;
    s       = '0;
    s.cfg   = `SSIR_CFG_RST;
    s.mux   = `SSIR_MUX_RST;
    s.emask = `SSIR_ERRCFG_RST;
    for (int i = 0; i < `SSIR_NCH; i++)
    begin
      s.rcnt[i] = `SSIR_RCOUNT_RST;
      s.stl[i]  = `SSIR_SETTLE_RST;
    end
    s.irq_n = 1'b1;
    s.cv    = SSIR_CV_IDLE;
    s.slp   = 1'b1;
    return s;
  endfunction

  // ***************************************************************
  // Link side, clocked by the serial clock; the start detector by the data line.
  // ***************************************************************

  ssir_lk_st_t lk_q;
  ssir_lk_st_t lk_d;
  ssir_drv_t   drv_q;
  ssir_drv_t   drv_d;
  logic        start_tog_q;
  ssir_st_t    q;
  ssir_st_t    d;
  logic        rd_pend;

  // A falling data line while the clock is high marks a start condition.
  always_ff @(negedge sda_i or posedge rst_i)
  begin
    if (rst_i)
      start_tog_q <= 1'b0;
    else if (link_scl_i)
      start_tog_q <= ~start_tog_q;
  end

  always_comb
  begin
    lk_d = lk_q;
    if (start_tog_q != lk_q.seen)
    begin
      lk_d.seen = start_tog_q;
      lk_d.ph   = SSIR_LK_ADDR;
      lk_d.cnt  = 4'h1;
      lk_d.sh   = {7'h00, sda_i};
    end
    else if (lk_q.ph != SSIR_LK_IDLE)
    begin
      if (lk_q.cnt != 4'h8)
      begin
        lk_d.sh  = {lk_q.sh[6:0], sda_i};
        lk_d.cnt = lk_q.cnt + 4'h1;
      end
      else
      begin
        lk_d.cnt = 4'h0;
        unique case (lk_q.ph)
          SSIR_LK_ADDR:
          begin
            if (lk_q.sh[7:1] != `SSIR_DEV_ADDR)
              lk_d.ph = SSIR_LK_IDLE;
            else if (lk_q.sh[0])
            begin
              lk_d.ph       = SSIR_LK_RD;
              lk_d.hib      = 1'b1;
              lk_d.req.addr = lk_q.ptr;
              lk_d.rd_tog   = ~lk_q.rd_tog;
            end
            else
              lk_d.ph = SSIR_LK_PTR;
          end
          SSIR_LK_PTR:
          begin
            lk_d.ptr = lk_q.sh;
            lk_d.ph  = SSIR_LK_WHI;
          end
          SSIR_LK_WHI:
          begin
            lk_d.req.wdata[15:8] = lk_q.sh;
            lk_d.ph              = SSIR_LK_WLO;
          end
          SSIR_LK_WLO:
          begin
            lk_d.req.wdata[7:0] = lk_q.sh;
            lk_d.req.addr       = lk_q.ptr;
            lk_d.wr_tog         = ~lk_q.wr_tog;
            lk_d.ptr            = lk_q.ptr + 8'h01;
            lk_d.ph             = SSIR_LK_WHI;
          end
          SSIR_LK_RD:
          begin
            if (sda_i)
              lk_d.ph = SSIR_LK_IDLE;
            else if (lk_q.hib)
              lk_d.hib = 1'b0;
            else
            begin
              lk_d.hib      = 1'b1;
              lk_d.ptr      = lk_q.ptr + 8'h01;
              lk_d.req.addr = lk_q.ptr + 8'h01;
              lk_d.rd_tog   = ~lk_q.rd_tog;
            end
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge link_scl_i or posedge rst_i)
  begin
    if (rst_i)
      lk_q <= '{ph: SSIR_LK_IDLE, default: '0};
    else
      lk_q <= lk_d;
  end

  // Data line changes only while the serial clock is low.
  always_comb
  begin
    drv_d     = '0;
    drv_d.ack = (lk_q.cnt == 4'h8) && (lk_q.ph != SSIR_LK_RD)
                && (lk_q.ph != SSIR_LK_IDLE)
                && ((lk_q.ph != SSIR_LK_ADDR) || (lk_q.sh[7:1] == `SSIR_DEV_ADDR));
    drv_d.tx  = (lk_q.ph == SSIR_LK_RD) && (lk_q.cnt != 4'h8);
    drv_d.idx = lk_q.hib ? 4'hf - lk_q.cnt : 4'h7 - lk_q.cnt;
  end

  always_ff @(negedge link_scl_i or posedge rst_i)
  begin
    if (rst_i)
      drv_q <= '0;
    else
      drv_q <= drv_d;
  end

  // The clock is held low until the read word has stood a cycle, so data never moves as it rises.
  assign rd_pend       = lk_q.rd_tog ^ q.rd_ack;
  assign link_scl_oe_o = rd_pend & drv_q.tx;
  assign sda_oe_o      = drv_q.ack | (drv_q.tx & ~q.rd_data[drv_q.idx]);

  // ***************************************************************
  // Core side, clocked by the main clock.
  // ***************************************************************

  logic                 sleeping;
  logic                 tick;
  logic [`SSIR_NCH-1:0] sens_edge;
  logic                 wr_ev;
  logic                 rd_ev;
  logic                 status_rd;
  logic                 msb_rd;
  logic                 conv_done;
  logic                 ev_or;
  logic                 ev_wd;
  logic                 ev_drdy;
  logic                 irq_set;
  logic                 swrst;
  logic [`SSIR_CHW-1:0] first_ch;
  logic [`SSIR_CHW-1:0] last_ch;
  logic [`SSIR_CHW-1:0] nxt_ch;
  logic [`SSIR_CHW-1:0] ach;
  logic [15:0]          live;
  logic [7:0]           a;
  ssir_st_t             t;

  always_comb
  begin
    d = q;
    t = '0;
    d.wsy  = {q.wsy[1:0], lk_q.wr_tog};
    d.rsy  = {q.rsy[1:0], lk_q.rd_tog};
    d.xsy  = {q.xsy[1:0], ext_clk_i};
    d.ssy  = {q.ssy[1:0], sens_i};
    d.sdsy = {q.sdsy[0], shutdown_in_i};
    d.rd_ack = q.rsy[2];
    wr_ev     = q.wsy[2] ^ q.wsy[1];
    rd_ev     = q.rsy[2] ^ q.rsy[1];
    sens_edge = q.ssy[1] & ~q.ssy[2];
    sleeping  = q.cfg[`SSIR_CFG_SLEEP] | q.sdsy[1];
    tick      = q.cfg[`SSIR_CFG_REFSEL] ? (q.xsy[1] & ~q.xsy[2]) : 1'b1;
    first_ch  = q.mux[`SSIR_MUX_SCAN] ? '0 : q.cfg[`SSIR_CFG_CHAN_LO +: `SSIR_CHW];
    // Group zero ends at channel 1; larger groups end at the top channel.
    last_ch   = q.mux[`SSIR_MUX_SCAN] ? `SSIR_CHW'(`SSIR_NCH - 1) : first_ch;
    nxt_ch    = (q.ch == last_ch) ? first_ch : q.ch + `SSIR_CHW'(1);
    a         = lk_q.req.addr;
    ach       = a[`SSIR_CHW:1];
    status_rd = 1'b0;
    msb_rd    = 1'b0;
    swrst     = 1'b0;
    conv_done = 1'b0;
    ev_or     = 1'b0;
    ev_wd     = 1'b0;
    ev_drdy   = 1'b0;
    live      = {q.err_chan, 1'b0, q.err_or, q.err_wd, 4'h0, q.drdy, 4'h0, q.unread};

    // Register reads, with their side effects.
    if (rd_ev)
    begin
      d.rd_data = 16'h0000;
      if (a == `SSIR_A_STATUS)
      begin
        d.rd_data = q.snap;
        status_rd = 1'b1;
      end
      else if (a < 8'(2 * `SSIR_NCH))
      begin
        if (!a[0])
        begin
          d.rd_data      = {4'h0, q.rbuf[ach][27:16]};
          d.vis_lo[ach]  = q.rbuf[ach][15:0];
          d.unread[ach]  = 1'b0;
          msb_rd         = 1'b1;
        end
        else
          d.rd_data = q.vis_lo[ach];
      end
      else if (a == `SSIR_A_ERRCFG)
        d.rd_data = q.emask;
      else if (a == `SSIR_A_CONFIG)
        d.rd_data = q.cfg;
      else if (a == `SSIR_A_MUXCFG)
        d.rd_data = q.mux;
      else if (a >= `SSIR_A_REF_COUNT_CH0 && a < `SSIR_A_REF_COUNT_CH0 + 8'(`SSIR_NCH))
        d.rd_data = q.rcnt[a[`SSIR_CHW-1:0]];
      else if (a >= `SSIR_A_SETTLE0 && a < `SSIR_A_SETTLE0 + 8'(`SSIR_NCH))
        d.rd_data = q.stl[a[`SSIR_CHW-1:0]];
    end

    // Register writes; setup registers accept writes only while asleep.
    if (wr_ev)
    begin
      if (a == `SSIR_A_CONFIG)
        d.cfg = lk_q.req.wdata;
      else if (a == `SSIR_A_SWRST)
        swrst = lk_q.req.wdata[`SSIR_SWRST_BIT];
      else if (q.cfg[`SSIR_CFG_SLEEP])
      begin
        if (a == `SSIR_A_ERRCFG)
          d.emask = lk_q.req.wdata;
        else if (a == `SSIR_A_MUXCFG)
          d.mux = lk_q.req.wdata;
        else if (a >= `SSIR_A_REF_COUNT_CH0 && a < `SSIR_A_REF_COUNT_CH0 + 8'(`SSIR_NCH))
          d.rcnt[a[`SSIR_CHW-1:0]] = lk_q.req.wdata;
        else if (a >= `SSIR_A_SETTLE0 && a < `SSIR_A_SETTLE0 + 8'(`SSIR_NCH))
          d.stl[a[`SSIR_CHW-1:0]] = lk_q.req.wdata;
      end
    end

    // Conversion sequencer.
    unique case (q.cv)
      SSIR_CV_IDLE:
      begin
        d.ch   = first_ch;
        d.tcnt = x16(q.stl[first_ch]);
        d.cv   = SSIR_CV_SETTLE;
      end
      SSIR_CV_SETTLE:
      begin
        if (tick)
        begin
          if (q.tcnt <= 20'h1)
          begin
            d.tcnt = x16(q.rcnt[q.ch]);
            d.ecnt = '0;
            d.cv   = SSIR_CV_CONV;
          end
          else
            d.tcnt = q.tcnt - 20'h1;
        end
      end
      SSIR_CV_CONV:
      begin
        if (sens_edge[q.ch] && q.ecnt != RES_MAX)
          d.ecnt = q.ecnt + `SSIR_RES_W'(1);
        if (tick)
        begin
          if (q.tcnt <= 20'h1)
          begin
            conv_done = 1'b1;
            d.cv      = SSIR_CV_NEXT;
          end
          else
            d.tcnt = q.tcnt - 20'h1;
        end
      end
      SSIR_CV_NEXT:
      begin
        d.ch   = nxt_ch;
        d.tcnt = x16(q.stl[nxt_ch]);
        d.cv   = SSIR_CV_SETTLE;
      end
    endcase

    // Clearing a flag on a read loses to a new event in the same cycle.
    if (status_rd)
    begin
      d.err_or   = 1'b0;
      d.err_wd   = 1'b0;
      d.drdy     = 1'b0;
      d.err_chan = 2'h0;
    end
    if (conv_done)
    begin
      d.rbuf[q.ch]   = q.ecnt;
      d.unread[q.ch] = 1'b1;
      ev_or          = (q.ecnt == RES_MAX);
      ev_wd          = (q.ecnt == '0);
      ev_drdy        = (q.ch == last_ch);
      if (ev_or)
        d.err_or = 1'b1;
      if (ev_wd)
        d.err_wd = 1'b1;
      if (ev_or || ev_wd)
        d.err_chan = 2'(q.ch);
      if (ev_drdy)
        d.drdy = 1'b1;
    end

    // Status word snapshot.
    if (status_rd || msb_rd)
      d.frozen = 1'b0;
    else if (!q.frozen)
    begin
      d.snap   = live;
      d.frozen = |live;
    end

    // Interrupt.
    irq_set = (ev_or && q.emask[`SSIR_EM_OR]) || (ev_wd && q.emask[`SSIR_EM_WD])
              || (ev_drdy && q.emask[`SSIR_EM_DRDY]);
    if (status_rd || msb_rd)
      d.irq = 1'b0;
    if (irq_set)
      d.irq = 1'b1;

    // Sleep and shutdown stop conversion and clear results.
    d.slp = sleeping;
    if (sleeping)
    begin
      d.cv     = SSIR_CV_IDLE;
      d.rbuf   = '0;
      d.vis_lo = '0;
      d.unread = '0;
      d.irq    = 1'b0;
    end
    if (q.slp && !sleeping)
      d.anl = '{rp_ovr:   q.cfg[`SSIR_CFG_RPOVR],
                wake_sel: q.cfg[`SSIR_CFG_WAKESEL],
                amp_dis:  q.cfg[`SSIR_CFG_AMPDIS]};

    // Software reset keeps the link handshake state intact.
    if (swrst)
    begin
      t         = st_rst();
      t.wsy     = d.wsy;
      t.rsy     = d.rsy;
      t.rd_ack  = d.rd_ack;
      t.rd_data = d.rd_data;
      d         = t;
    end
    d.irq_n = ~(d.irq & ~d.cfg[`SSIR_CFG_IRQDIS]);
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      q <= st_rst();
    else
      q <= d;
  end

  assign irq_out_n_o = q.irq_n;
  assign anl_cfg_o   = q.anl;

  // ***************************************************************
  // Assertions.
  // ***************************************************************

  a_irq_disabled_high: assert property (@(posedge mclk_i) disable iff (rst_i)
    q.cfg[`SSIR_CFG_IRQDIS] |-> irq_out_n_o)
    else $error("interrupt pin low while disabled");
  a_irq_needs_mask: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!q.irq && d.irq) |-> irq_set)
    else $error("interrupt raised without an unmasked event");
  a_irq_pin_follows: assert property (@(posedge mclk_i) disable iff (rst_i)
    (q.irq && !q.cfg[`SSIR_CFG_IRQDIS]) |-> !irq_out_n_o)
    else $error("interrupt pin not low for a pending event");
  a_read_releases_irq: assert property (@(posedge mclk_i) disable iff (rst_i)
    ((status_rd || msb_rd) && !irq_set) |=> irq_out_n_o)
    else $error("interrupt pin not released after read");
  a_status_frozen: assert property (@(posedge mclk_i) disable iff (rst_i)
    (q.frozen && !status_rd && !msb_rd && !swrst) |=> $stable(q.snap))
    else $error("frozen status word changed");
  a_sleep_clears: assert property (@(posedge mclk_i) disable iff (rst_i)
    (sleeping && !swrst) |=> (q.rbuf == '0) && (q.vis_lo == '0) && !q.irq)
    else $error("results or interrupt survive sleep");
  a_msb_clears_unread: assert property (@(posedge mclk_i) disable iff (rst_i)
    (msb_rd && !(conv_done && q.ch == ach) && !swrst) |=> !q.unread[$past(ach)])
    else $error("unread flag kept after upper read");
  a_lsb_holds: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!msb_rd && !sleeping && !swrst) |=> $stable(q.vis_lo))
    else $error("lower word changed without upper read");
  a_conv_length: assert property (@(posedge mclk_i) disable iff (rst_i)
    (q.cv == SSIR_CV_SETTLE && d.cv == SSIR_CV_CONV) |=> q.tcnt == 20'(q.rcnt[q.ch]) * 20'h10)
    else $error("conversion length not sixteen reference periods per count");
  a_mask_reset: assert property (@(posedge mclk_i)
    (!rst_i && $past(rst_i)) |-> (q.emask == 16'h0000) && q.cfg[`SSIR_CFG_SLEEP])
    else $error("mask or sleep wrong after reset");

  c_drdy_irq: cover property (@(posedge mclk_i) disable iff (rst_i)
    ev_drdy && q.emask[`SSIR_EM_DRDY] ##1 !irq_out_n_o);
  c_status_read: cover property (@(posedge mclk_i) disable iff (rst_i)
    status_rd && q.frozen);
  c_msb_read: cover property (@(posedge mclk_i) disable iff (rst_i)
    msb_rd && q.unread[ach]);

endmodule

// file: rtl/ssir_regs.svh
// Register offsets, field positions, reset values and timing figures.
// Assumes a two-channel converter reached over a two-wire serial link.
`ifndef SSIR_REGS_SVH
`define SSIR_REGS_SVH

`define SSIR_NCH          2
`define SSIR_CHW          1
`define SSIR_RES_W        28
`define SSIR_A_DATA0      8'h00
`define SSIR_A_REF_COUNT_CH0    8'h08
`define SSIR_A_SETTLE0    8'h10
`define SSIR_A_STATUS     8'h18
`define SSIR_A_ERRCFG     8'h19
`define SSIR_A_CONFIG     8'h1a
`define SSIR_A_MUXCFG     8'h1b
`define SSIR_A_SWRST      8'h1c
`define SSIR_CFG_RST      16'h2801
`define SSIR_MUX_RST      16'h0000
`define SSIR_ERRCFG_RST   16'h0000
`define SSIR_RCOUNT_RST   16'h0080
`define SSIR_SETTLE_RST   16'h0000
`define SSIR_CFG_CHAN_LO  14
`define SSIR_CFG_SLEEP    13
`define SSIR_CFG_RPOVR    12
`define SSIR_CFG_WAKESEL  11
`define SSIR_CFG_AMPDIS   10
`define SSIR_CFG_REFSEL   9
`define SSIR_CFG_IRQDIS   7
`define SSIR_MUX_SCAN     15
`define SSIR_MUX_GRP_HI   14
`define SSIR_MUX_GRP_LO   13
`define SSIR_SWRST_BIT    15
`define SSIR_EM_OR        6
`define SSIR_EM_WD        5
`define SSIR_EM_DRDY      0
`define SSIR_REF_PER_CNT  4
`define SSIR_DEV_ADDR     7'h2a

`endif

// file: rtl/ssir_pkg.sv
// Types shared by the status, interrupt and readback block.
// Assumes ssir_regs.svh is on the include path.
`include "ssir_regs.svh"

package ssir_pkg;

  typedef enum logic [3:0] {
    SSIR_CV_IDLE   = 4'h1,
    SSIR_CV_SETTLE = 4'h2,
    SSIR_CV_CONV   = 4'h4,
    SSIR_CV_NEXT   = 4'h8
  } ssir_cv_t;

  typedef enum logic [5:0] {
    SSIR_LK_IDLE = 6'h01,
    SSIR_LK_ADDR = 6'h02,
    SSIR_LK_PTR  = 6'h04,
    SSIR_LK_WHI  = 6'h08,
    SSIR_LK_WLO  = 6'h10,
    SSIR_LK_RD   = 6'h20
  } ssir_lk_ph_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
  } ssir_req_t;

  typedef struct packed {
    logic rp_ovr;
    logic wake_sel;
    logic amp_dis;
  } ssir_anl_t;

  typedef struct packed {
    ssir_lk_ph_t ph;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        hib;
    logic [7:0]  ptr;
    ssir_req_t   req;
    logic        wr_tog;
    logic        rd_tog;
    logic        seen;
  } ssir_lk_st_t;

  typedef struct packed {
    logic       ack;
    logic       tx;
    logic [3:0] idx;
  } ssir_drv_t;

  typedef struct packed {
    logic [15:0]                                cfg;
    logic [15:0]                                mux;
    logic [15:0]                                emask;
    logic [`SSIR_NCH-1:0][15:0]                 rcnt;
    logic [`SSIR_NCH-1:0][15:0]                 stl;
    logic [`SSIR_NCH-1:0][`SSIR_RES_W-1:0]      rbuf;
    logic [`SSIR_NCH-1:0][15:0]                 vis_lo;
    logic [`SSIR_NCH-1:0]                       unread;
    logic                                       err_or;
    logic                                       err_wd;
    logic                                       drdy;
    logic [1:0]                                 err_chan;
    logic [15:0]                                snap;
    logic                                       frozen;
    logic                                       irq;
    logic                                       irq_n;
    ssir_cv_t                                   cv;
    logic [`SSIR_CHW-1:0]                       ch;
    logic [19:0]                                tcnt;
    logic [`SSIR_RES_W-1:0]                     ecnt;
    logic [15:0]                                rd_data;
    logic                                       rd_ack;
    logic [2:0]                                 wsy;
    logic [2:0]                                 rsy;
    logic [2:0]                                 xsy;
    logic [2:0][`SSIR_NCH-1:0]                  ssy;
    logic [1:0]                                 sdsy;
    logic                                       slp;
    ssir_anl_t                                  anl;
  } ssir_st_t;

endpackage

// file: dv/ssir_host.sv
// Two-wire host model issuing word writes and word reads.
// Assumes the bench resolves both wires with pull-ups from all pull-downs.
`include "ssir_regs.svh"
module ssir_host (
  // Pull-downs onto the wires.
  output logic      scl_lo_o,
  output logic      sda_lo_o,
  // Resolved wire levels.
  input  wire logic scl_i,
  input  wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    scl_lo_o = 1'b0;
    sda_lo_o = 1'b0;
  end
  // ****************
  // Bit level
  // ****************
  // The clock is released and then awaited, so device stretching is honoured.
  task automatic bit_io(input logic b, output logic r);
    #40 sda_lo_o = !b;
    #40 scl_lo_o = 1'b0;
    wait (scl_i === 1'b1);
    #40 r = sda_i;
    #40 scl_lo_o = 1'b1;
  endtask
  task automatic sda_hi_edge(input logic lo);
    #40 scl_lo_o = 1'b0;
    wait (scl_i === 1'b1);
    #40 sda_lo_o = lo;
    #40;
  endtask
  task automatic start();
    sda_lo_o = 1'b0;
    sda_hi_edge(1'b1);
    scl_lo_o = 1'b1;
  endtask
  // The clock stands high after a frame.
  task automatic stop();
    #40 sda_lo_o = 1'b1;
    sda_hi_edge(1'b0);
  endtask
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--)
      bit_io(d[i], q[i]);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    logic [8:0] q;
    start();
    xfer({`SSIR_DEV_ADDR, 2'b01}, q);
    xfer({a, 1'b1}, q);
    xfer({v[15:8], 1'b1}, q);
    xfer({v[7:0], 1'b1}, q);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    logic [8:0] q;
    start();
    xfer({`SSIR_DEV_ADDR, 2'b01}, q);
    xfer({a, 1'b1}, q);
    start();
    xfer({`SSIR_DEV_ADDR, 2'b11}, q);
    xfer({8'hff, 1'b0}, q);
    v[15:8] = q[8:1];
    xfer({8'hff, 1'b1}, q);
    v[7:0] = q[8:1];
    stop();
  endtask
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the status, interrupt and readback core.
// Assumes the host model and the package are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0, rst_i = 1'b0, shutdown_in_i = 1'b0, ext_clk_i = 1'b0;
  logic [1:0] sens_i = 2'h0, cnt = 2'h0;
  logic scl_oe, sda_oe, h_scl, h_sda, irq_n;
  wire scl = !(scl_oe || h_scl);
  wire sda = !(sda_oe || h_sda);
  ssir_pkg::ssir_anl_t anl;
  int error_cnt = 0, comparisons = 0, cyc = 0, n;
  logic [15:0] v, w;
  ssir_core uut (.mclk_i(mclk_i), .rst_i(rst_i), .link_scl_i(scl), .sda_i(sda),
    .link_scl_oe_o(scl_oe), .sda_oe_o(sda_oe), .ext_clk_i(ext_clk_i), .sens_i(sens_i),
    .shutdown_in_i(shutdown_in_i), .irq_out_n_o(irq_n), .anl_cfg_o(anl));
  ssir_host host (.scl_lo_o(h_scl), .sda_lo_o(h_sda), .scl_i(scl), .sda_i(sda));
  // ****************
  // Stimulus and checks
  // ****************
  always #50 mclk_i = !mclk_i;
  // Sensor 0 rises every 2 cycles, sensor 1 every 4, reference every 2.
  always @(posedge mclk_i)
  begin
    cnt <= cnt + 2'h1;
    sens_i <= cnt;
    ext_clk_i <= cnt[0];
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wait_irq(output int k);
    for (k = 0; k < 3000 && irq_n !== 1'b0; k++)
      @(negedge mclk_i);
  endtask
  // Counts the cycles with the pin low over a fixed span.
  task automatic quiet(output int k);
    k = 0;
    repeat (700)
    begin
      @(negedge mclk_i);
      k += (irq_n === 1'b0);
    end
  endtask
  task automatic s_single();
    host.rd(8'h19, v);
    chk("mask", 16'h0, v);
    host.rd(8'h1a, v);
    chk("config", 16'h2801, v);
    chk("irq idle", 16'h1, irq_n);
    host.wr(8'h08, 16'h0010);
    host.wr(8'h10, 16'h0001);
    host.wr(8'h19, 16'h0001);
    host.wr(8'h1a, 16'h0801);
    wait_irq(n);
    chk("conv time", 16'h1, n > 260 && n < 400);
    chk("analog cfg", 16'h2, anl);
    host.rd(8'h18, v);
    chk("status", 16'h0041, v & 16'h0043);
    chk("irq read", 16'h1, irq_n);
    host.rd(8'h00, v);
    host.rd(8'h01, v);
    chk("lower", 16'h1, v inside {[126:130]});
    repeat (700) @(posedge mclk_i);
    host.rd(8'h01, w);
    chk("lower held", v, w);
  endtask
  task automatic s_irq_ctl();
    host.wr(8'h1a, 16'h1881);
    repeat (8) @(posedge mclk_i);
    quiet(n);
    chk("disabled low", 16'h0, n);
    chk("analog held", 16'h2, anl);
    host.wr(8'h1a, 16'h0801);
    wait_irq(n);
    chk("enabled", 16'h0, irq_n);
    @(posedge mclk_i) shutdown_in_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    chk("irq shutdown", 16'h1, irq_n);
    shutdown_in_i <= 1'b0;
    host.wr(8'h1a, 16'h2801);
    host.rd(8'h01, v);
    chk("lower cleared", 16'h0, v);
    host.wr(8'h19, 16'h0000);
    host.wr(8'h1a, 16'h0801);
    quiet(n);
    chk("masked low", 16'h0, n);
    host.wr(8'h19, 16'h0001);
    host.rd(8'h19, v);
    chk("active write", 16'h0, v);
    host.wr(8'h1a, 16'h2801);
    host.wr(8'h19, 16'h0001);
    host.wr(8'h1a, 16'h0801);
    wait_irq(n);
    host.wr(8'h1c, 16'h8000);
    repeat (4) @(posedge mclk_i);
    chk("irq swrst", 16'h1, irq_n);
    host.rd(8'h1a, v);
    chk("config swrst", 16'h2801, v);
  endtask
  task automatic s_scan();
    host.wr(8'h08, 16'h0010);
    host.wr(8'h09, 16'h0010);
    host.wr(8'h10, 16'h0001);
    host.wr(8'h11, 16'h0001);
    host.wr(8'h19, 16'h0001);
    host.wr(8'h1b, 16'h8000);
    host.wr(8'h1a, 16'h0a01);
    wait_irq(n);
    chk("group irq", 16'h0, irq_n);
    host.rd(8'h02, v);
    host.rd(8'h03, v);
    chk("ch1 lower", 16'h1, v inside {[126:130]});
  endtask
  initial
  begin
    // Raised at time zero so the link side's asynchronous reset sees an edge.
    rst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    s_single();
    s_irq_ctl();
    s_scan();
    give_verdict();
  end
endmodule
